/* File: thermostat_pkg.sv */
// shared constants, types and helpers of the thermostat sensor control
package thermostat_pkg;

	localparam int CLK_HZ             = 100_000_000;
	localparam int NVM_WRITE_MS       = 10;
	localparam int NVM_WRITE_CYCLES   = NVM_WRITE_MS * (CLK_HZ / 1000);
	localparam int PULSE_LIMIT_MS     = 10;
	localparam int PULSE_LIMIT_CYCLES = PULSE_LIMIT_MS * (CLK_HZ / 1000);
	localparam int TIMER_W            = 24;

	localparam logic [7:0] CMD_READ_TEMP  = 8'haa;
	localparam logic [7:0] CMD_WRITE_HIGH = 8'h01;
	localparam logic [7:0] CMD_WRITE_LOW  = 8'h02;
	localparam logic [7:0] CMD_READ_HIGH  = 8'ha1;
	localparam logic [7:0] CMD_READ_LOW   = 8'ha2;
	localparam logic [7:0] CMD_START      = 8'hee;
	localparam logic [7:0] CMD_STOP       = 8'h22;
	localparam logic [7:0] CMD_WRITE_CFG  = 8'h0c;
	localparam logic [7:0] CMD_READ_CFG   = 8'hac;

	localparam logic [3:0] CMD_BITS  = 4'h8;
	localparam logic [3:0] TEMP_BITS = 4'h9;
	localparam logic [3:0] CFG_BITS  = 4'h8;

	localparam int CFG_DONE_BIT       = 7;
	localparam int CFG_HIGH_FLAG_BIT  = 6;
	localparam int CFG_LOW_FLAG_BIT   = 5;
	localparam int CFG_NVM_BUSY_BIT   = 4;
	localparam int CFG_ONE_BIT        = 3;
	localparam int CFG_ZERO_BIT       = 2;
	localparam int CFG_PORT_SEL_BIT   = 1;
	localparam int CFG_SINGLE_BIT     = 0;

	localparam logic       RST_HOST_PORT_SELECT = 1'b1;
	localparam logic       RST_SINGLE           = 1'b0;
	localparam logic [8:0] RST_HIGH_LIMIT       = 9'h0fa;
	localparam logic [8:0] RST_LOW_LIMIT        = 9'h192;
	localparam logic [8:0] RST_TEMP             = 9'h000;

	typedef enum logic [1:0] {
		CONV_IDLE = 2'b01,
		CONV_BUSY = 2'b10
	} conv_state_t;

	typedef enum logic [3:0] {
		SER_CMD  = 4'b0001,
		SER_WR   = 4'b0010,
		SER_RD   = 4'b0100,
		SER_SKIP = 4'b1000
	} ser_state_t;

	function automatic logic temp_at_or_above(input logic [8:0] a, input logic [8:0] b);
		temp_at_or_above = $signed(a) >= $signed(b);
	endfunction : temp_at_or_above

	function automatic logic temp_at_or_below(input logic [8:0] a, input logic [8:0] b);
		temp_at_or_below = $signed(a) <= $signed(b);
	endfunction : temp_at_or_below

endpackage : thermostat_pkg

/* File: pin_sync.sv */
// two-stage synchroniser for the three serial port pins
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	input  wire logic [2:0] pins_async,
	output logic      [2:0] pins_sync
);

	logic [2:0] stage1_reg;
	logic [2:0] stage1_next;
	logic [2:0] stage2_reg;
	logic [2:0] stage2_next;

	// first stage feeds only the second
	always_comb begin
		stage1_next = stage1_reg;
		stage2_next = stage2_reg;
		if (clk_en) begin
			stage1_next = pins_async;
			stage2_next = stage1_reg;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			// clock pin idles high, so no false edge follows reset
			stage1_reg <= 3'h2;
			stage2_reg <= 3'h2;
		end else begin
			stage1_reg <= stage1_next;
			stage2_reg <= stage2_next;
		end
	end

	assign pins_sync = stage2_reg;

endmodule : pin_sync
`default_nettype wire

/* File: limit_compare.sv */
// thermostat outputs, updated once per completed conversion
`timescale 1ns/10ps
`default_nettype none
module limit_compare (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	input  wire logic       update,
	input  wire logic [8:0] temp,
	input  wire logic [8:0] high_limit,
	input  wire logic [8:0] low_limit,
	output logic            over_limit_out,
	output logic            under_limit_out,
	output logic            hysteresis_out
);

	logic over_reg;
	logic over_next;
	logic under_reg;
	logic under_next;
	logic hyst_reg;
	logic hyst_next;

	// outputs hold between conversions, so one-shot keeps the last result
	always_comb begin
		over_next  = over_reg;
		under_next = under_reg;
		hyst_next  = hyst_reg;
		if (clk_en && update) begin
			over_next  = thermostat_pkg::temp_at_or_above(temp, high_limit);
			under_next = thermostat_pkg::temp_at_or_below(temp, low_limit);
			if (!thermostat_pkg::temp_at_or_below(temp, high_limit)) begin
				hyst_next = 1'b1;
			end else if (!thermostat_pkg::temp_at_or_above(temp, low_limit)) begin
				hyst_next = 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			over_reg  <= 1'b0;
			under_reg <= 1'b0;
			hyst_reg  <= 1'b0;
		end else begin
			over_reg  <= over_next;
			under_reg <= under_next;
			hyst_reg  <= hyst_next;
		end
	end

	assign over_limit_out  = over_reg;
	assign under_limit_out = under_reg;
	assign hysteresis_out  = hyst_reg;

endmodule : limit_compare
`default_nettype wire

/* File: thermostat_sensor_serial_control.sv */
// control logic of the thermostat temperature sensor with three-wire port
// Summary of operation
// - done bit set on finish, zero continuous
// - high flag sticks until written zero
// - low flag sticks until written zero
// - nvm busy high during nonvolatile write
// - port select picks convert or serial clock
// - single bit: one conversion or continuous
// - config byte field order fixed
// - one-shot outputs hold last conversion result
// - short low pulse triggers one conversion
// - long low level converts continuously
// - standalone pin overrides single conversion bit
// - enable low aborts transfer, releases data
// - input bits sampled on rising edge
// - drive on falling edge, float while high
// - everything shifted least significant bit first
// - command aah reads nine-bit temperature
// - commands 01h/02h write high/low limit
// - commands a1h/a2h read high/low limit
// - command eeh starts conversion
// - command 22h stops after current measurement
// - commands 0ch/ach write/read config byte
// - nine-bit two's complement half-degree values
// - over output follows at-or-above high limit
// - under output follows at-or-below low limit
// - hysteresis set above high, cleared below low
`timescale 1ns/10ps
`default_nettype none
module thermostat_sensor_serial_control #(
	parameter int NVM_WRITE_CYCLES   = thermostat_pkg::NVM_WRITE_CYCLES,
	parameter int PULSE_LIMIT_CYCLES = thermostat_pkg::PULSE_LIMIT_CYCLES
) (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	input  wire logic       xfer_en,
	input  wire logic       clock_or_convert,
	input  wire logic       data_in,
	output logic            data_out,
	output logic            data_oe,
	output logic            conv_req,
	input  wire logic       conv_done,
	input  wire logic [8:0] conv_result,
	output logic            over_limit_out,
	output logic            under_limit_out,
	output logic            hysteresis_out
);

	localparam logic [thermostat_pkg::TIMER_W-1:0] NVM_LOAD =
		thermostat_pkg::TIMER_W'(NVM_WRITE_CYCLES);
	localparam logic [thermostat_pkg::TIMER_W-1:0] PULSE_LAST =
		thermostat_pkg::TIMER_W'(PULSE_LIMIT_CYCLES - 1);

	logic [2:0] pins_s;
	logic       xfer_s;
	logic       sclk_s;
	logic       din_s;
	logic       sclk_prev_reg;
	logic       sclk_rise;
	logic       sclk_fall;

	pin_sync u_pin_sync (
		.core_clk   (core_clk),
		.rst_n      (rst_n),
		.clk_en     (clk_en),
		.pins_async ({data_in, clock_or_convert, xfer_en}),
		.pins_sync  (pins_s)
	);

	assign xfer_s    = pins_s[0];
	assign sclk_s    = pins_s[1];
	assign din_s     = pins_s[2];
	assign sclk_rise = clk_en & sclk_s & ~sclk_prev_reg;
	assign sclk_fall = clk_en & ~sclk_s & sclk_prev_reg;

	// serial port state
	thermostat_pkg::ser_state_t ser_state_reg;
	thermostat_pkg::ser_state_t ser_state_next;
	logic [3:0] bit_cnt_reg;
	logic [3:0] bit_cnt_next;
	logic [8:0] shift_reg;
	logic [8:0] shift_next;
	logic [7:0] cmd_reg;
	logic [7:0] cmd_next;
	logic       dout_reg;
	logic       dout_next;
	logic       doe_reg;
	logic       doe_next;
	logic [7:0] cmd_byte;
	logic [3:0] data_len;
	logic       wr_high_p;
	logic       wr_low_p;
	logic       wr_cfg_p;
	logic       start_cmd_p;
	logic       stop_cmd_p;
	logic [8:0] wr_data;

	// configuration, limits and conversion state
	thermostat_pkg::conv_state_t conv_state_reg;
	thermostat_pkg::conv_state_t conv_state_next;
	logic       cont_run_reg;
	logic       cont_run_next;
	logic       port_sel_reg;
	logic       port_sel_next;
	logic       single_reg;
	logic       single_next;
	logic       high_flag_reg;
	logic       high_flag_next;
	logic       low_flag_reg;
	logic       low_flag_next;
	logic       done_reg;
	logic       done_next;
	logic [8:0] high_limit_reg;
	logic [8:0] high_limit_next;
	logic [8:0] low_limit_reg;
	logic [8:0] low_limit_next;
	logic [8:0] temp_reg;
	logic [8:0] temp_next;
	logic [thermostat_pkg::TIMER_W-1:0] nvm_cnt_reg;
	logic [thermostat_pkg::TIMER_W-1:0] nvm_cnt_next;
	logic       nvm_busy;
	logic       conv_finish;
	logic [7:0] cfg_byte;

	// standalone convert pin state
	logic [thermostat_pkg::TIMER_W-1:0] sa_cnt_reg;
	logic [thermostat_pkg::TIMER_W-1:0] sa_cnt_next;
	logic       sa_hold_reg;
	logic       sa_hold_next;
	logic       sa_active;
	logic       sa_start;

	assign nvm_busy    = nvm_cnt_reg != '0;
	assign conv_finish = clk_en & conv_done & (conv_state_reg == thermostat_pkg::CONV_BUSY);

	always_comb begin
		cfg_byte = 8'h00;
		cfg_byte[thermostat_pkg::CFG_DONE_BIT]      = done_reg & single_reg & ~sa_hold_reg;
		cfg_byte[thermostat_pkg::CFG_HIGH_FLAG_BIT] = high_flag_reg;
		cfg_byte[thermostat_pkg::CFG_LOW_FLAG_BIT]  = low_flag_reg;
		cfg_byte[thermostat_pkg::CFG_NVM_BUSY_BIT]  = nvm_busy;
		cfg_byte[thermostat_pkg::CFG_ONE_BIT]       = 1'b1;
		cfg_byte[thermostat_pkg::CFG_ZERO_BIT]      = 1'b0;
		cfg_byte[thermostat_pkg::CFG_PORT_SEL_BIT]  = port_sel_reg;
		cfg_byte[thermostat_pkg::CFG_SINGLE_BIT]    = single_reg;
	end

	// serial port: sample on rising edge, drive on falling edge
	always_comb begin
		ser_state_next = ser_state_reg;
		bit_cnt_next   = bit_cnt_reg;
		shift_next     = shift_reg;
		cmd_next       = cmd_reg;
		dout_next      = dout_reg;
		doe_next       = doe_reg;
		wr_high_p      = 1'b0;
		wr_low_p       = 1'b0;
		wr_cfg_p       = 1'b0;
		start_cmd_p    = 1'b0;
		stop_cmd_p     = 1'b0;
		cmd_byte       = {din_s, shift_reg[8:2]};
		wr_data        = {din_s, shift_reg[8:1]};
		data_len       = (cmd_reg == thermostat_pkg::CMD_WRITE_CFG ||
			cmd_reg == thermostat_pkg::CMD_READ_CFG) ? thermostat_pkg::CFG_BITS
			: thermostat_pkg::TEMP_BITS;
		if (clk_en) begin
			if (!xfer_s) begin
				ser_state_next = thermostat_pkg::SER_CMD;
				bit_cnt_next   = 4'h0;
				doe_next       = 1'b0;
			end else begin
				case (ser_state_reg)
					thermostat_pkg::SER_CMD: begin
						if (sclk_rise) begin
							shift_next   = {din_s, shift_reg[8:1]};
							bit_cnt_next = bit_cnt_reg + 4'h1;
							if (bit_cnt_reg == thermostat_pkg::CMD_BITS - 4'h1) begin
								cmd_next       = cmd_byte;
								bit_cnt_next   = 4'h0;
								ser_state_next = thermostat_pkg::SER_SKIP;
								case (cmd_byte)
									thermostat_pkg::CMD_READ_TEMP: begin
										shift_next     = temp_reg;
										ser_state_next = thermostat_pkg::SER_RD;
									end
									thermostat_pkg::CMD_READ_HIGH: begin
										shift_next     = high_limit_reg;
										ser_state_next = thermostat_pkg::SER_RD;
									end
									thermostat_pkg::CMD_READ_LOW: begin
										shift_next     = low_limit_reg;
										ser_state_next = thermostat_pkg::SER_RD;
									end
									thermostat_pkg::CMD_READ_CFG: begin
										shift_next     = {1'b0, cfg_byte};
										ser_state_next = thermostat_pkg::SER_RD;
									end
									thermostat_pkg::CMD_WRITE_HIGH,
									thermostat_pkg::CMD_WRITE_LOW,
									thermostat_pkg::CMD_WRITE_CFG: begin
										ser_state_next = thermostat_pkg::SER_WR;
									end
									thermostat_pkg::CMD_START: start_cmd_p = 1'b1;
									thermostat_pkg::CMD_STOP:  stop_cmd_p  = 1'b1;
									default: ser_state_next = thermostat_pkg::SER_SKIP;
								endcase
							end
						end
					end
					thermostat_pkg::SER_WR: begin
						if (sclk_rise) begin
							shift_next   = {din_s, shift_reg[8:1]};
							bit_cnt_next = bit_cnt_reg + 4'h1;
							if (bit_cnt_reg == data_len - 4'h1) begin
								// partial words end with the enable and are dropped
								wr_high_p      = cmd_reg == thermostat_pkg::CMD_WRITE_HIGH;
								wr_low_p       = cmd_reg == thermostat_pkg::CMD_WRITE_LOW;
								wr_cfg_p       = cmd_reg == thermostat_pkg::CMD_WRITE_CFG;
								ser_state_next = thermostat_pkg::SER_SKIP;
							end
						end
					end
					thermostat_pkg::SER_RD: begin
						if (sclk_fall) begin
							dout_next = shift_reg[0];
							doe_next  = 1'b1;
						end else if (sclk_rise) begin
							doe_next     = 1'b0;
							shift_next   = {1'b0, shift_reg[8:1]};
							bit_cnt_next = bit_cnt_reg + 4'h1;
							if (bit_cnt_reg == data_len - 4'h1) begin
								ser_state_next = thermostat_pkg::SER_SKIP;
							end
						end
					end
					thermostat_pkg::SER_SKIP: begin
						doe_next = 1'b0;
					end
					default: begin
						ser_state_next = thermostat_pkg::SER_CMD;
						doe_next       = 1'b0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ser_state_reg <= thermostat_pkg::SER_CMD;
			bit_cnt_reg   <= 4'h0;
			shift_reg     <= 9'h000;
			cmd_reg       <= 8'h00;
			dout_reg      <= 1'b0;
			doe_reg       <= 1'b0;
			sclk_prev_reg <= 1'b1;
		end else begin
			ser_state_reg <= ser_state_next;
			bit_cnt_reg   <= bit_cnt_next;
			shift_reg     <= shift_next;
			cmd_reg       <= cmd_next;
			dout_reg      <= dout_next;
			doe_reg       <= doe_next;
			sclk_prev_reg <= clk_en ? sclk_s : sclk_prev_reg;
		end
	end

	// standalone pin only counts while the port is deselected
	assign sa_active = ~port_sel_reg & ~xfer_s;
	assign sa_start  = sa_active & sclk_fall;

	always_comb begin
		sa_cnt_next  = sa_cnt_reg;
		sa_hold_next = sa_hold_reg;
		if (clk_en) begin
			if (sa_active && !sclk_s) begin
				if (sa_cnt_reg != PULSE_LAST) begin
					sa_cnt_next = sa_cnt_reg + 1'b1;
				end else begin
					sa_hold_next = 1'b1;
				end
			end else begin
				sa_cnt_next  = '0;
				sa_hold_next = 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sa_cnt_reg  <= '0;
			sa_hold_reg <= 1'b0;
		end else begin
			sa_cnt_reg  <= sa_cnt_next;
			sa_hold_reg <= sa_hold_next;
		end
	end

	// conversion sequencing, limits and configuration
	always_comb begin
		conv_state_next = conv_state_reg;
		cont_run_next   = cont_run_reg;
		port_sel_next   = port_sel_reg;
		single_next     = single_reg;
		high_flag_next  = high_flag_reg;
		low_flag_next   = low_flag_reg;
		done_next       = done_reg;
		high_limit_next = high_limit_reg;
		low_limit_next  = low_limit_reg;
		temp_next       = temp_reg;
		nvm_cnt_next    = nvm_cnt_reg;
		if (clk_en) begin
			if (nvm_busy) begin
				nvm_cnt_next = nvm_cnt_reg - 1'b1;
			end
			if (wr_high_p) begin
				high_limit_next = wr_data;
				nvm_cnt_next    = NVM_LOAD;
			end
			if (wr_low_p) begin
				low_limit_next = wr_data;
				nvm_cnt_next   = NVM_LOAD;
			end
			if (wr_cfg_p) begin
				// writing one to a flag does nothing; only zero clears
				if (!wr_data[thermostat_pkg::CFG_HIGH_FLAG_BIT + 1]) begin
					high_flag_next = 1'b0;
				end
				if (!wr_data[thermostat_pkg::CFG_LOW_FLAG_BIT + 1]) begin
					low_flag_next = 1'b0;
				end
				port_sel_next = wr_data[thermostat_pkg::CFG_PORT_SEL_BIT + 1];
				single_next   = wr_data[thermostat_pkg::CFG_SINGLE_BIT + 1];
				nvm_cnt_next  = NVM_LOAD;
			end
			if (start_cmd_p) begin
				cont_run_next = ~single_reg;
			end
			if (stop_cmd_p) begin
				cont_run_next = 1'b0;
			end
			case (conv_state_reg)
				thermostat_pkg::CONV_IDLE: begin
					if (start_cmd_p || sa_start || sa_hold_reg) begin
						conv_state_next = thermostat_pkg::CONV_BUSY;
						done_next       = 1'b0;
					end
				end
				thermostat_pkg::CONV_BUSY: begin
					if (conv_done) begin
						temp_next = conv_result;
						done_next = 1'b1;
						// set after the clear so a same-cycle event is kept
						if (thermostat_pkg::temp_at_or_above(conv_result, high_limit_reg)) begin
							high_flag_next = 1'b1;
						end
						if (thermostat_pkg::temp_at_or_below(conv_result, low_limit_reg)) begin
							low_flag_next = 1'b1;
						end
						if (!(cont_run_next || sa_hold_reg)) begin
							conv_state_next = thermostat_pkg::CONV_IDLE;
						end else begin
							done_next = 1'b0;
						end
					end
				end
				default: conv_state_next = thermostat_pkg::CONV_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			conv_state_reg <= thermostat_pkg::CONV_IDLE;
			cont_run_reg   <= 1'b0;
			port_sel_reg   <= thermostat_pkg::RST_HOST_PORT_SELECT;
			single_reg     <= thermostat_pkg::RST_SINGLE;
			high_flag_reg  <= 1'b0;
			low_flag_reg   <= 1'b0;
			done_reg       <= 1'b0;
			high_limit_reg <= thermostat_pkg::RST_HIGH_LIMIT;
			low_limit_reg  <= thermostat_pkg::RST_LOW_LIMIT;
			temp_reg       <= thermostat_pkg::RST_TEMP;
			nvm_cnt_reg    <= '0;
		end else begin
			conv_state_reg <= conv_state_next;
			cont_run_reg   <= cont_run_next;
			port_sel_reg   <= port_sel_next;
			single_reg     <= single_next;
			high_flag_reg  <= high_flag_next;
			low_flag_reg   <= low_flag_next;
			done_reg       <= done_next;
			high_limit_reg <= high_limit_next;
			low_limit_reg  <= low_limit_next;
			temp_reg       <= temp_next;
			nvm_cnt_reg    <= nvm_cnt_next;
		end
	end

	limit_compare u_limit_compare (
		.core_clk        (core_clk),
		.rst_n           (rst_n),
		.clk_en          (clk_en),
		.update          (conv_finish),
		.temp            (conv_result),
		.high_limit      (high_limit_reg),
		.low_limit       (low_limit_reg),
		.over_limit_out  (over_limit_out),
		.under_limit_out (under_limit_out),
		.hysteresis_out  (hysteresis_out)
	);

	assign data_out = dout_reg;
	assign data_oe  = doe_reg;
	assign conv_req = conv_state_reg == thermostat_pkg::CONV_BUSY;

endmodule : thermostat_sensor_serial_control
`default_nettype wire

/* File: thermostat_monitor.sv */
// concurrent checks on the thermostat control ports
`timescale 1ns/10ps
`default_nettype none
module thermostat_monitor #(
	parameter int NVM_WRITE_CYCLES   = 1,
	parameter int PULSE_LIMIT_CYCLES = 1
) (
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic       clk_en,
	input wire logic       xfer_en,
	input wire logic       clock_or_convert,
	input wire logic       data_in,
	input wire logic       data_out,
	input wire logic       data_oe,
	input wire logic       conv_req,
	input wire logic       conv_done,
	input wire logic [8:0] conv_result,
	input wire logic       over_limit_out,
	input wire logic       under_limit_out,
	input wire logic       hysteresis_out
);
	default clocking mon_cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// sync delay of the pins leaves room of a few cycles
	sequence link_idle_s;
		!xfer_en [*6];
	endsequence
	sequence no_update_s;
		!$past(conv_done) && !$past(conv_done, 2);
	endsequence
	oe_release_a: assert property (link_idle_s |-> !data_oe)
		else $error("data line driven after transfer end");
	float_high_a: assert property ($rose(clock_or_convert) |-> ##5 !data_oe)
		else $error("data line driven while clock high");
	drive_low_a: assert property ($rose(data_oe) |-> !clock_or_convert && xfer_en)
		else $error("data drive started outside clock low");
	bit_stable_a: assert property (data_oe && $past(data_oe) |-> $stable(data_out))
		else $error("driven bit changed while held");
	over_hold_a: assert property (no_update_s |-> $stable(over_limit_out))
		else $error("over output moved without conversion");
	under_hold_a: assert property (no_update_s |-> $stable(under_limit_out))
		else $error("under output moved without conversion");
	hyst_hold_a: assert property (no_update_s |-> $stable(hysteresis_out))
		else $error("hysteresis output moved without conversion");
	conv_end_a: assert property ($fell(conv_req) |-> $past(conv_done) || $past(conv_done, 2))
		else $error("conversion ended without result");
	hyst_over_a: assert property ($rose(hysteresis_out) |-> over_limit_out)
		else $error("hysteresis set below high limit");
	hyst_under_a: assert property ($fell(hysteresis_out) |-> under_limit_out)
		else $error("hysteresis cleared above low limit");
endmodule : thermostat_monitor
bind thermostat_sensor_serial_control thermostat_monitor #(
	.NVM_WRITE_CYCLES(NVM_WRITE_CYCLES),
	.PULSE_LIMIT_CYCLES(PULSE_LIMIT_CYCLES)
) u_thermostat_monitor (
	.core_clk(core_clk),
	.rst_n(rst_n),
	.clk_en(clk_en),
	.xfer_en(xfer_en),
	.clock_or_convert(clock_or_convert),
	.data_in(data_in),
	.data_out(data_out),
	.data_oe(data_oe),
	.conv_req(conv_req),
	.conv_done(conv_done),
	.conv_result(conv_result),
	.over_limit_out(over_limit_out),
	.under_limit_out(under_limit_out),
	.hysteresis_out(hysteresis_out)
);
`default_nettype wire

/* File: serial_host_model.sv */
// host side of the three-wire port: transfer enable, clock and data line
`timescale 1ns/10ps
`default_nettype none
module serial_host_model (
	input  wire logic core_clk,
	input  wire logic data_out,
	input  wire logic data_oe,
	output var logic  xfer_en,
	output var logic  clock_or_convert,
	output wire logic data_in
);
	logic host_oe;
	logic host_bit;
	initial begin
		xfer_en = 1'b0;
		clock_or_convert = 1'b1;
		host_oe = 1'b0;
		host_bit = 1'b0;
	end
	// released line shows the inverse so a stale bit cannot pass
	assign data_in = data_oe ? data_out : (host_oe ? host_bit : ~data_out);
	// stop: loop index after which enable drops with clock low
	task automatic xfer(input logic [7:0] cmd, input logic [8:0] wd, input int nw,
		input int nr, input int stop, output logic [8:0] rd);
		logic [16:0] w;
		w = {wd, cmd};
		rd = 9'h000;
		xfer_en = 1'b1;
		repeat (4) @(negedge core_clk);
		for (int i = 0; i < 8 + nw + nr; i++) begin
			clock_or_convert = 1'b0;
			host_oe = (i < 8 + nw);
			host_bit = w[i];
			repeat (4) @(negedge core_clk);
			if (i >= 8 + nw)
				rd[i - 8 - nw] = data_in;
			if (i == stop)
				break;
			clock_or_convert = 1'b1;
			repeat (4) @(negedge core_clk);
		end
		host_oe = 1'b0;
		xfer_en = 1'b0;
		repeat (4) @(negedge core_clk);
		clock_or_convert = 1'b1;
		repeat (4) @(negedge core_clk);
	endtask : xfer
	task automatic convert_low(input int n);
		clock_or_convert = 1'b0;
		repeat (n) @(negedge core_clk);
		clock_or_convert = 1'b1;
	endtask : convert_low
endmodule : serial_host_model
`default_nettype wire

/* File: thermostat_sensor_serial_control_test.sv */
// self-checking bench of the thermostat control through its serial port
`timescale 1ns/10ps
`default_nettype none
module thermostat_sensor_serial_control_test;
	localparam int NVM_W   = 400;
	localparam int PULSE_W = 40;
	logic       core_clk  = 1'b0;
	logic       rst_n     = 1'b0;
	logic       clk_en    = 1'b1;
	logic       conv_done = 1'b0;
	logic [8:0] temp_val  = 9'h000;
	logic [8:0] rd;
	wire        xfer_en, clock_or_convert, data_in, data_out, data_oe, conv_req;
	wire        over, under, hyst;
	int         err_total = 0;
	int         cmp_count = 0;
	int         cnt       = 0;
	int         ndone     = 0;
	int         n0;
	always #5 core_clk = ~core_clk;
	thermostat_sensor_serial_control #(
		.NVM_WRITE_CYCLES(NVM_W),
		.PULSE_LIMIT_CYCLES(PULSE_W)
	) u_thermostat_sensor_serial_control (
		.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .xfer_en(xfer_en),
		.clock_or_convert(clock_or_convert), .data_in(data_in), .data_out(data_out),
		.data_oe(data_oe), .conv_req(conv_req), .conv_done(conv_done),
		.conv_result(temp_val), .over_limit_out(over), .under_limit_out(under),
		.hysteresis_out(hyst)
	);
	serial_host_model u_serial_host_model (
		.core_clk(core_clk), .data_out(data_out), .data_oe(data_oe), .xfer_en(xfer_en),
		.clock_or_convert(clock_or_convert), .data_in(data_in)
	);
	// converter stand-in: result twenty cycles into each conversion
	always @(negedge core_clk) begin
		conv_done <= 1'b0;
		cnt <= (conv_req === 1'b1) ? cnt + 1 : 0;
		if (conv_req === 1'b1 && cnt == 19) begin
			conv_done <= 1'b1;
			cnt <= 0;
			ndone <= ndone + 1;
		end
	end
	task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc
	task automatic wr(input logic [7:0] cmd, input logic [8:0] val, input int nw);
		u_serial_host_model.xfer(cmd, val, nw, 0, 99, rd);
		cyc(NVM_W + 20);
	endtask : wr
	task automatic rdv(input logic [7:0] cmd, input int nr, input logic [8:0] exp,
		input string name);
		u_serial_host_model.xfer(cmd, 9'h000, 0, nr, 99, rd);
		chk(name, exp, rd);
	endtask : rdv
	task automatic cmd(input logic [7:0] c);
		u_serial_host_model.xfer(c, 9'h000, 0, 0, 99, rd);
	endtask : cmd
	task automatic wait_req(input logic v, input int n);
		for (int i = 0; i < n && conv_req !== v; i++)
			cyc(1);
		chk("conv_req", v, {8'h00, conv_req});
	endtask : wait_req
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	initial begin
		#300us;
		err_total++;
		end_of_test();
	end
	initial begin
		cyc(5);
		rst_n = 1'b1;
		cyc(3);
		u_serial_host_model.xfer(8'h01, 9'h050, 9, 0, 99, rd);
		rdv(8'hac, 8, 9'h01a, "config busy");
		cyc(NVM_W);
		rdv(8'hac, 8, 9'h00a, "config idle");
		wr(8'h02, 9'h014, 9);
		rdv(8'ha1, 9, 9'h050, "high_limit");
		rdv(8'ha2, 9, 9'h014, "low_limit");
		$display("test limits done");
		temp_val = 9'h060;
		wr(8'h0c, 9'h003, 8);
		n0 = ndone;
		cmd(8'hee);
		wait_req(1'b0, 40);
		cyc(40);
		chk("one shot", 9'h001, 9'(ndone - n0));
		rdv(8'haa, 9, 9'h060, "temperature");
		rdv(8'hac, 8, 9'h0cb, "config hot");
		chk("outputs hot", 9'h005, {6'h00, over, under, hyst});
		wr(8'h0c, 9'h003, 8);
		rdv(8'hac, 8, 9'h08b, "flag cleared");
		// minus half a degree: an unsigned compare would call it hot
		temp_val = 9'h1ff;
		cmd(8'hee);
		wait_req(1'b0, 40);
		rdv(8'hac, 8, 9'h0ab, "config cold");
		chk("outputs cold", 9'h002, {6'h00, over, under, hyst});
		$display("test one shot done");
		temp_val = 9'h030;
		wr(8'h0c, 9'h002, 8);
		n0 = ndone;
		cmd(8'hee);
		rdv(8'hac, 8, 9'h00a, "config running");
		chk("continuous", 9'h001, 9'(ndone - n0 > 2));
		cmd(8'h22);
		wait_req(1'b0, 30);
		cyc(40);
		chk("stopped", 9'h000, {8'h00, conv_req});
		$display("test continuous done");
		u_serial_host_model.xfer(8'haa, 9'h000, 0, 9, 11, rd);
		chk("data_oe", 9'h000, {8'h00, data_oe});
		rdv(8'ha2, 9, 9'h014, "after abort");
		$display("test abort done");
		u_serial_host_model.convert_low(10);
		cyc(10);
		chk("port clock", 9'h000, {8'h00, conv_req});
		wr(8'h0c, 9'h001, 8);
		n0 = ndone;
		u_serial_host_model.convert_low(10);
		wait_req(1'b1, 10);
		wait_req(1'b0, 40);
		cyc(40);
		chk("one pulse", 9'h001, 9'(ndone - n0));
		n0 = ndone;
		u_serial_host_model.convert_low(120);
		chk("held low", 9'h001, {8'h00, conv_req});
		wait_req(1'b0, 30);
		chk("long low", 9'h001, 9'(ndone - n0 > 3));
		$display("test standalone done");
		end_of_test();
	end
endmodule : thermostat_sensor_serial_control_test
`default_nettype wire
